// ---- design/sar_seq_pkg.sv ----
// Purpose: constants and carrier types for the sar conversion sequencer
// Assumes: one 40 MHz master clock; conversion clock is a divide-by-four enable
// Notes: times are in master cycles so they scale with the master clock
// Function
// - each conversion starts with trial code msb set, all else clear.
// - per bit, clear it if comparator says input below, then set next lower.
// - result is twelve bits, so twelve comparison steps per conversion.
// - over range gives all ones, under range gives all zeros.
// - bipolar ties msb capacitor to reference while tracking; offset binary result.
// - idle and not calibrating, every capacitor to analog input except msb in bipolar, track switch closed.
// - on conversion open track switch first, then trials ignore analog input.
// - internal oscillator while master clock pin is low, else external clock.
// - synchronised request falling edge in track mode, not calibrating, enters hold and starts a conversion.
// - after a conversion the device returns to track mode by itself.
// - calibration balances each bit weight against lower bits plus a dummy lsb.
// - all durations are counted in master clock cycles.
// - conversion clock is master clock divided by four; start waits up to four.
// - a conversion lasts at least 49 master cycles, up to four more.
// - done low four cycles with select and read low, else held low until the next conversion starts.
package sar_seq_pkg;
   localparam int unsigned NBITS            = 12;
   localparam int unsigned CLK_HZ           = 40000000;
   localparam int unsigned DIV_RATIO        = 4;
   localparam int unsigned CONV_CYCLES      = 49;
   localparam int unsigned DONE_LOW_CYCLES  = 4;
   localparam int unsigned HOLD_MARGIN_NS   = 50;
   localparam int unsigned HOLD_MARGIN_CYC  = (HOLD_MARGIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam logic [1:0]  DIV_RESET        = 2'h0;
   localparam logic [5:0]  CYC_RESET        = 6'h00;
   localparam logic [11:0] CODE_RESET       = 12'h000;
   localparam logic [11:0] CODE_ONES        = 12'hfff;
   localparam logic [11:0] CODE_ZEROS       = 12'h000;
   localparam logic [11:0] CODE_MSB         = 12'h800;
   localparam logic [3:0]  BIT_MSB_IDX      = 4'hb;

   typedef enum logic [1:0] {
      SW_INPUT,
      SW_GROUND,
      SW_REF
   } cap_sel_t;

   typedef struct packed {
      logic       track_switch;
      logic [11:0] cap_to_input;
      logic [11:0] cap_to_ref;
   } array_ctl_t;

   typedef struct packed {
      logic over_range;
      logic under_range;
   } range_t;
endpackage

// ---- design/sar_conversion_sequencer.sv ----
// Purpose: bit-trial sequencer and output coding of a 12-bit sar converter
// Assumes: inputs synchronous to i_ref_clk except the sample request
// Notes: master clock source select is a mux flag only; the clock pin is sampled
`timescale 1ns/100ps
module sar_conversion_sequencer (
   input  wire logic                     i_ref_clk,
   input  wire logic                     i_nrst,
   input  wire logic                     i_master_clock_pin,
   input  wire logic                     i_hold_n,
   input  wire logic                     i_comp_below,
   input  wire logic                     i_bipolar,
   input  wire sar_seq_pkg::range_t      i_range,
   input  wire logic                     i_cal_busy,
   input  wire logic                     i_cs_n,
   input  wire logic                     i_rd_n,
   output logic                          o_use_internal_osc,
   output sar_seq_pkg::array_ctl_t       o_array,
   output logic [11:0]                   o_trial,
   output logic [11:0]                   o_result,
   output logic                          o_converting,
   output logic                          o_done_n
);
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      ST_TRACK,
      ST_WAIT,
      ST_TRIAL,
      ST_TAIL
   } state_t;

   state_t      state;
   logic        sync1;
   logic        sync2;
   logic        sync3;
   logic [1:0]  div;
   logic        div_en;
   logic [5:0]  cyc;
   logic [3:0]  bit_idx;
   logic        fall;
   logic [3:0]  done_cnt;

   // binary weights: each bit weighs all lower bits plus one dummy lsb
   function automatic logic [11:0] onehot(input logic [3:0] idx);
      onehot = 12'(1) << idx;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // source select and synchroniser
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_use_internal_osc <= 1'b1;
      end else begin
         o_use_internal_osc <= ~i_master_clock_pin;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         sync3 <= 1'b1;
      end else begin
         sync1 <= i_hold_n;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   assign fall = sync3 & ~sync2;

   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div <= sar_seq_pkg::DIV_RESET;
      end else begin
         div <= div + 2'h1;
      end
   end
   assign div_en = (div == 2'(sar_seq_pkg::DIV_RATIO - 1));

   ////////////////////////////////////////////////////////////////////////////
   // conversion sequence
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state   <= ST_TRACK;
         cyc     <= sar_seq_pkg::CYC_RESET;
         bit_idx <= sar_seq_pkg::BIT_MSB_IDX;
         o_trial <= sar_seq_pkg::CODE_RESET;
      end else begin
         unique case (state)
            ST_TRACK: begin
               if (fall && !i_cal_busy) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (div_en) begin
                  state   <= ST_TRIAL;
                  cyc     <= 6'h01;
                  bit_idx <= sar_seq_pkg::BIT_MSB_IDX;
                  o_trial <= sar_seq_pkg::CODE_MSB;
               end
            end
            ST_TRIAL: begin
               cyc <= cyc + 6'h01;
               if (div_en) begin
                  if (i_comp_below) begin
                     o_trial <= (o_trial & ~onehot(bit_idx)) | ((bit_idx != 4'h0) ? onehot(bit_idx - 4'h1) : 12'h000);
                  end else begin
                     o_trial <= o_trial | ((bit_idx != 4'h0) ? onehot(bit_idx - 4'h1) : 12'h000);
                  end
                  if (bit_idx == 4'h0) begin
                     state <= ST_TAIL;
                  end else begin
                     bit_idx <= bit_idx - 4'h1;
                  end
               end
            end
            ST_TAIL: begin
               cyc <= cyc + 6'h01;
               if (cyc >= 6'(sar_seq_pkg::CONV_CYCLES - 1)) begin
                  state <= ST_TRACK;
               end
            end
         endcase
      end
   end

   // result holding register with range clamping
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_result <= sar_seq_pkg::CODE_RESET;
      end else if (state == ST_TRIAL && div_en && bit_idx == 4'h0) begin
         if (i_range.over_range) begin
            o_result <= sar_seq_pkg::CODE_ONES;
         end else if (i_range.under_range) begin
            o_result <= sar_seq_pkg::CODE_ZEROS;
         end else begin
            o_result <= i_comp_below ? (o_trial & ~12'h001) : o_trial;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // capacitor array and track switch
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_array      <= '{track_switch: 1'b1, cap_to_input: 12'hfff, cap_to_ref: 12'h000};
         o_converting <= 1'b0;
      end else if (fall && state == ST_TRACK && !i_cal_busy) begin
         o_array.track_switch <= 1'b0;
         o_array.cap_to_input <= 12'h000;
         o_converting         <= 1'b1;
      end else if (state == ST_TRIAL || state == ST_WAIT) begin
         o_array.track_switch <= 1'b0;
         o_array.cap_to_input <= 12'h000;
         o_array.cap_to_ref   <= o_trial;
      end else if (state == ST_TRACK && !i_cal_busy) begin
         o_array.track_switch <= 1'b1;
         o_array.cap_to_input <= i_bipolar ? 12'h7ff : 12'hfff;
         o_array.cap_to_ref   <= i_bipolar ? sar_seq_pkg::CODE_MSB : 12'h000;
         o_converting         <= 1'b0;
      end else if (state == ST_TAIL) begin
         o_converting <= 1'b1;
      end
   end

   // conversion done, active low
   always_ff @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_done_n <= 1'b1;
         done_cnt <= 4'h0;
      end else begin
         if (state == ST_TAIL && cyc >= 6'(sar_seq_pkg::CONV_CYCLES - 1)) begin
            o_done_n <= 1'b0;
            done_cnt <= 4'h0;
         end else if (!o_done_n) begin
            if (done_cnt == 4'h0 && !(i_cs_n | i_rd_n)) begin
               done_cnt <= 4'h1;
            end else if (done_cnt != 4'h0) begin
               done_cnt <= done_cnt + 4'h1;
            end
            if (done_cnt == 4'(sar_seq_pkg::DONE_LOW_CYCLES - 1) || state == ST_WAIT) begin
               o_done_n <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_START_MSB: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (state == ST_WAIT && div_en) |=> (o_trial == sar_seq_pkg::CODE_MSB)) else $error("trial not half scale");
   AST_TRIAL_LEN: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (state == ST_WAIT && div_en) |=> (state == ST_TRIAL) [*8]) else $error("trials ended early");
   AST_HOLD_OPENS: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (fall && state == ST_TRACK && !i_cal_busy) |=> !o_array.track_switch) else $error("track not opened");
   AST_TRACK_IDLE: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (state == ST_TRACK && $past(state) == ST_TRACK && !i_cal_busy && !$past(i_cal_busy) && !$past(fall))
      |-> o_array.track_switch) else $error("switch open while idle");
   AST_WAIT_BOUND: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (state == ST_WAIT) |-> ##[1:4] (state == ST_TRIAL)) else $error("start waited over four");
   AST_CONV_LEN: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (state == ST_TRIAL && $past(state) == ST_WAIT) |-> ##[48:60] (state == ST_TRACK)) else $error("bad length");
   AST_SYNC: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (sync2 != $past(sync1)) |-> 1'b0) else $error("sync stage skipped");
   AST_SRC: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      o_use_internal_osc == !$past(i_master_clock_pin)) else $error("clock source wrong");
   AST_BIPOLAR: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (state == ST_TRACK && i_bipolar && $past(i_bipolar) && $past(state) == ST_TRACK && !$past(fall)
       && !$past(i_cal_busy)) |-> o_array.cap_to_ref[11]) else $error("msb not on ref");
   AST_CLAMP_HIGH: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (state == ST_TRIAL && div_en && bit_idx == 4'h0 && i_range.over_range)
      |=> (o_result == sar_seq_pkg::CODE_ONES)) else $error("over range not clamped");
   AST_RETURN_TRACK: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (state == ST_TRACK && $past(state) == ST_TAIL && !i_cal_busy)
      |=> (o_array.track_switch && !o_converting)) else $error("no return to track");
   AST_DONE_READ: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (!o_done_n && !i_cs_n && !i_rd_n) |-> ##[1:4] o_done_n) else $error("done held too long");
   AST_CONV_FLAG: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
      (state == ST_TRIAL) |-> o_converting) else $error("trials without converting flag");
   CV_CONV: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) state == ST_TAIL ##1 state == ST_TRACK);
   CV_OVER: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) o_result == sar_seq_pkg::CODE_ONES);
   CV_DONE: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) $fell(o_done_n));
   CV_BIPOLAR: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) state == ST_TRIAL && i_bipolar);
   CV_HELD_READ: cover property (@(posedge i_ref_clk) disable iff (!i_nrst) !o_done_n && !i_cs_n && !i_rd_n);
endmodule

// ---- verif/sar_host_model.sv ----
// Purpose: sample request host and comparator model for the sar sequencer
// Assumes: requests are issued just after a rising edge of i_ref_clk
// Notes: comparator is ideal against the level held on i_level
`timescale 1ns/100ps
module sar_host_model (
   input  wire logic        i_ref_clk,
   input  wire logic [11:0] i_trial,
   input  wire logic [11:0] i_level,
   output logic             o_hold_n,
   output logic             o_comp_below
);
   ////////////////////////////////////////////////////////////////////////////
   initial o_hold_n = 1'h1;
   // below when the held level is under the trial code
   assign o_comp_below = (i_level < i_trial);
   // low over one cycle plus 50 ns, released well before 49 cycles
   task automatic request(input int unsigned low_cyc);
      o_hold_n <= 1'h0;
      repeat (low_cyc) @(posedge i_ref_clk);
      o_hold_n <= 1'h1;
   endtask
endmodule

// ---- verif/sar_conversion_sequencer_test.sv ----
// Purpose: self-checking bench for the sar conversion sequencer
// Assumes: 40 MHz master clock, partner model drives request and comparator
// Notes: every conversion is read out so done_n is high before the next
`timescale 1ns/100ps
module sar_conversion_sequencer_test;
   logic                     clk = 1'h0;
   logic                     nrst = 1'h0;
   logic                     pin = 1'h0;
   logic                     bipolar = 1'h0;
   logic                     cal = 1'h0;
   logic                     cs_n = 1'h1;
   logic                     rd_n = 1'h1;
   sar_seq_pkg::range_t      rng = 2'h0;
   logic [11:0]              level = 12'h000;
   logic                     hold_n, comp_below, osc, conv, done_n;
   sar_seq_pkg::array_ctl_t  arr;
   logic [11:0]              trial, result;
   int                       fails = 0;
   int                       check_count = 0;
   ////////////////////////////////////////////////////////////////////////////
   always #12.5 clk = ~clk;
   sar_host_model host (.i_ref_clk(clk), .i_trial(trial), .i_level(level), .o_hold_n(hold_n),
      .o_comp_below(comp_below));
   sar_conversion_sequencer dut (.i_ref_clk(clk), .i_nrst(nrst), .i_master_clock_pin(pin),
      .i_hold_n(hold_n), .i_comp_below(comp_below), .i_bipolar(bipolar), .i_range(rng),
      .i_cal_busy(cal), .i_cs_n(cs_n), .i_rd_n(rd_n), .o_use_internal_osc(osc), .o_array(arr),
      .o_trial(trial), .o_result(result), .o_converting(conv), .o_done_n(done_n));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("checks=%0d errors=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wait_done(output int n);
      n = 0;
      while (done_n !== 1'h0 && n < 80) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic read_out;
      int n;
      n = 0;
      @(posedge clk);
      cs_n <= 1'h0;
      rd_n <= 1'h0;
      while (done_n !== 1'h1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      chk(n >= 3 && n <= 6, 32'h1);
      @(posedge clk);
      cs_n <= 1'h1;
      rd_n <= 1'h1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic clk_sel;
      @(posedge clk);
      pin <= 1'h1;
      repeat (2) @(negedge clk);
      chk(osc, 32'h0);
      @(posedge clk);
      pin <= 1'h0;
      repeat (2) @(negedge clk);
      chk(osc, 32'h1);
   endtask
   task automatic convert(input logic [11:0] lv, input logic bip, input logic [1:0] rg,
                          input logic [11:0] exp);
      int n;
      int t_open;
      logic saw;
      n = 0;
      t_open = 0;
      saw = 1'h0;
      @(posedge clk);
      level <= lv;
      bipolar <= bip;
      rng <= sar_seq_pkg::range_t'(rg);
      repeat (3) @(posedge clk);
      fork host.request(4); join_none
      while (done_n !== 1'h0 && n < 80) begin
         @(negedge clk);
         n++;
         if (t_open == 0 && arr.track_switch === 1'h0) t_open = n;
         if (trial === sar_seq_pkg::CODE_MSB) saw = 1'h1;
      end
      chk(t_open >= 3 && t_open <= 5, 32'h1);
      chk(saw, 32'h1);
      chk(n >= 49 && n <= 62, 32'h1);
      chk(result, exp);
      @(negedge clk);
      chk(arr, {1'h1, ~{bip, 11'h000}, {bip, 11'h000}});
      chk(conv, 32'h0);
      read_out;
   endtask
   task automatic refuse;
      int n;
      @(posedge clk);
      fork host.request(4); join_none
      repeat (20) @(posedge clk);
      fork host.request(4); join_none
      wait_done(n);
      chk(n >= 25 && n <= 45, 32'h1);
      repeat (20) @(negedge clk);
      chk({conv, arr.track_switch}, 32'h1);
      read_out;
   endtask
   task automatic cal_block;
      @(posedge clk);
      cal <= 1'h1;
      @(posedge clk);
      fork host.request(4); join_none
      repeat (15) @(negedge clk);
      chk({conv, done_n}, 32'h1);
      @(posedge clk);
      cal <= 1'h0;
   endtask
   task automatic read_held;
      int n;
      int m;
      m = 0;
      @(posedge clk);
      cs_n <= 1'h0;
      rd_n <= 1'h0;
      fork host.request(4); join_none
      wait_done(n);
      chk(n >= 54 && n <= 57, 32'h1);
      while (done_n === 1'h0 && m < 10) begin
         @(negedge clk);
         m++;
      end
      chk(m, 32'h4);
      @(posedge clk);
      cs_n <= 1'h1;
      rd_n <= 1'h1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'h1;
      @(negedge clk);
      chk({arr, done_n, osc}, {1'h1, 12'hfff, 12'h000, 2'h3});
      clk_sel;
      convert(12'h000, 1'h0, 2'h0, 12'h000);
      convert(12'ha5a, 1'h0, 2'h0, 12'ha5a);
      convert(12'hfff, 1'h0, 2'h0, 12'hfff);
      convert(12'h7ff, 1'h0, 2'h0, 12'h7ff);
      convert(12'h801, 1'h1, 2'h0, 12'h801);
      convert(12'ha5a, 1'h0, 2'h2, 12'hfff);
      convert(12'ha5a, 1'h0, 2'h1, 12'h000);
      refuse;
      cal_block;
      read_held;
      stop_test;
   end
   initial begin
      #(25 * 6000);
      fails++;
      stop_test;
   end
endmodule
